/* File: bblu_cfg.svh */
// constants for the bus branching and loop-around unit
`ifndef BBLU_CFG_SVH
`define BBLU_CFG_SVH
`define BBLU_ADDR_W      16
`define BBLU_WRITE_W     40
`define BBLU_POLL_W      8
`define BBLU_REPLY_W     32
`define BBLU_FWD_W       64
`define BBLU_ADDR_LSB    0
`define BBLU_WRITE_LSB   16
`define BBLU_POLL_LSB    56
`define BBLU_BRANCHES    4
`define BBLU_SECT_W      12
`define BBLU_LOOP_W      24
`define BBLU_MAPS        3
`define BBLU_IDX_W       6
`define BBLU_TABLE_W     432
`define BBLU_POLL_HIGH   3
`define BBLU_POLL_LOW    4
`define BBLU_POLL_SEIZE  5
`define BBLU_POLL_DIGIT  6
`define BBLU_MAP_INHIBIT 2'h0
`define BBLU_MAP_ONE     2'h1
`define BBLU_MAP_TWO     2'h2
`define BBLU_MAP_THREE   2'h3
`endif

/* File: bblu_pkg.sv */
// types and default mapping table for the branching loop-around unit
`include "bblu_cfg.svh"
package bblu_pkg;
   typedef enum logic [1:0] {
      BBLU_INHIBIT = `BBLU_MAP_INHIBIT,
      BBLU_MAP1    = `BBLU_MAP_ONE,
      BBLU_MAP2    = `BBLU_MAP_TWO,
      BBLU_MAP3    = `BBLU_MAP_THREE
   } bblu_map_e;

   typedef logic [`BBLU_FWD_W-1:0]   bblu_fwd_t;
   typedef logic [`BBLU_TABLE_W-1:0] bblu_table_t;

   // default: mapping m, capture bit i takes forward bit (24*m + i) mod 64
   function automatic bblu_table_t bblu_default_table();
      bblu_table_t t;
      int          n;
      t = '0;
      for (int m = 0; m < `BBLU_MAPS; m++) begin
         for (int i = 0; i < `BBLU_LOOP_W; i++) begin
            n = (m * `BBLU_LOOP_W + i) % `BBLU_FWD_W;
            t[(m * `BBLU_LOOP_W + i) * `BBLU_IDX_W +: `BBLU_IDX_W] = n[`BBLU_IDX_W-1:0];
         end
      end
      return t;
   endfunction : bblu_default_table
endpackage : bblu_pkg

/* File: bblu_sect_if.sv */
// carrier between the top and one 12-bit loop-around section
`timescale 1ns/1ns
`include "bblu_cfg.svh"
interface bblu_sect_if;
   logic [3:0]                           map_pls;  // inhibit, map1, map2, map3
   logic                                 en;
   logic [`BBLU_MAPS-1:0][`BBLU_SECT_W-1:0] cand;  // candidate bits per mapping
   logic [`BBLU_SECT_W-1:0]              word;     // gated captured word
   logic                                 clearing;

   modport sect (input map_pls, input en, input cand, output word, output clearing);
   modport top  (output map_pls, output en, output cand, input word, input clearing);
endinterface : bblu_sect_if

/* File: bblu_section.sv */
// one 12-bit section of a loop-around capture register
`timescale 1ns/1ns
`include "bblu_cfg.svh"
module bblu_section (
   input wire logic   i_ref_clk,
   input wire logic   i_rst_b,
   bblu_sect_if.sect  s
);
   bblu_pkg::bblu_map_e     map_ff;
   logic [4:0]              prev_ff;
   logic                    clr_ff;
   logic [`BBLU_SECT_W-1:0] cap_ff;
   logic [4:0]              pls_now;
   logic                    trailing;
   logic                    nxt_clr;
   logic [`BBLU_SECT_W-1:0] sel_bits;
   logic [`BBLU_SECT_W-1:0] nxt_cap;

   // trailing edge of enable or any mapping-select pulse
   assign pls_now  = {s.en, s.map_pls};
   assign trailing = |(prev_ff & ~pls_now);

   // mapping state decides which bits the gated inputs see
   // inhibit keeps every gated input closed
   assign sel_bits = (map_ff == bblu_pkg::BBLU_MAP1) ? s.cand[0] :
                     (map_ff == bblu_pkg::BBLU_MAP2) ? s.cand[1] :
                     (map_ff == bblu_pkg::BBLU_MAP3) ? s.cand[2] : '0;

   // edge sets clearing; drops once all twelve bits are zero
   assign nxt_clr = trailing | (clr_ff & (cap_ff != '0));

   // set-only capture held until the next clearing
   // every bit has its own gated input
   assign nxt_cap = clr_ff ? '0 : (cap_ff | sel_bits);

   // enable gates the captured word, or zeros, toward the reply path
   assign s.word     = s.en ? cap_ff : '0;
   assign s.clearing = clr_ff;

   // each select pulse loads its own state; inhibit wins a tie
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         map_ff <= bblu_pkg::BBLU_INHIBIT;
      end else if (s.map_pls[0]) begin
         map_ff <= bblu_pkg::BBLU_INHIBIT;
      end else if (s.map_pls[1]) begin
         map_ff <= bblu_pkg::BBLU_MAP1;
      end else if (s.map_pls[2]) begin
         map_ff <= bblu_pkg::BBLU_MAP2;
      end else if (s.map_pls[3]) begin
         map_ff <= bblu_pkg::BBLU_MAP3;
      end
   end

   // capture, clearing and edge history
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_ff <= 5'h00;
         clr_ff  <= 1'b0;
         cap_ff  <= 12'h000;
      end else begin
         prev_ff <= pls_now;
         clr_ff  <= nxt_clr;
         cap_ff  <= nxt_cap;
      end
   end
endmodule : bblu_section

/* File: bblu_top.sv */
// branching and loop-around unit for one peripheral bus
`timescale 1ns/1ns
`include "bblu_cfg.svh"
module bblu_top #(
   parameter bblu_pkg::bblu_table_t MAP_TABLE = bblu_pkg::bblu_default_table()
) (
   input  wire logic                                          i_ref_clk,
   input  wire logic                                          i_rst_b,
   input  wire logic [`BBLU_ADDR_W-1:0]                       i_addr_grp,
   input  wire logic [`BBLU_WRITE_W-1:0]                      i_write_grp,
   input  wire logic [`BBLU_POLL_W-1:0]                       i_poll_grp,
   output logic      [`BBLU_ADDR_W-1:0]                       o_addr_thru,
   output logic      [`BBLU_WRITE_W-1:0]                      o_write_thru,
   output logic      [`BBLU_POLL_W-1:0]                       o_poll_thru,
   output logic      [`BBLU_BRANCHES-1:0][`BBLU_ADDR_W-1:0]   o_br_addr,
   output logic      [`BBLU_BRANCHES-1:0][`BBLU_WRITE_W-1:0]  o_br_write,
   output logic      [`BBLU_BRANCHES-1:0][`BBLU_POLL_W-1:0]   o_br_poll,
   input  wire logic [`BBLU_BRANCHES-1:0]                     i_exp_poll_sel,
   input  wire logic [3:0]                                    i_exp_poll,
   input  wire logic [`BBLU_BRANCHES-1:0][`BBLU_REPLY_W-1:0]  i_br_reply,
   input  wire logic [`BBLU_REPLY_W-1:0]                      i_reply_chain,
   output logic      [`BBLU_REPLY_W-1:0]                      o_reply,
   input  wire logic [1:0]                                    i_loop_en_ab,
   input  wire logic [1:0]                                    i_loop_en_cd,
   input  wire logic [1:0][3:0]                               i_map_sel,
   output logic      [1:0][3:0]                               o_map_sel_thru,
   input  wire logic [1:0]                                    i_clamp_set,
   input  wire logic [1:0]                                    i_clamp_clr,
   output logic      [1:0]                                    o_clamp_set_thru,
   output logic      [1:0]                                    o_clamp_clr_thru,
   output logic                                               o_clamp,
   output logic      [3:0]                                    o_clearing
);
   bblu_pkg::bblu_fwd_t                     fwd_in;
   bblu_pkg::bblu_fwd_t                     copy_ff [2];
   bblu_pkg::bblu_fwd_t                     br_ff   [`BBLU_BRANCHES];
   logic [`BBLU_REPLY_W-1:0]                nxt_reply;
   logic [`BBLU_REPLY_W-1:0]                br_or;
   logic [`BBLU_REPLY_W-1:0]                loop_field;
   logic [1:0][`BBLU_LOOP_W-1:0]            loop_word;
   logic [3:0]                              map_any;
   logic [1:0]                              loop_en;
   logic                                    clamp_ff;
   logic                                    nxt_clamp;
   logic [3:0]                              clearing;
   logic                                    clamp_set_any;
   logic                                    clamp_clr_any;
   logic [`BBLU_REPLY_W-1:0]                reply_local;
   logic [`BBLU_LOOP_W-1:0]                 loop_any;

   // one carrier per section: A/B low, A/B high, C/D low, C/D high
   bblu_sect_if sect_if [4] ();

   assign fwd_in = {i_poll_grp, i_write_grp, i_addr_grp};

   // either control's copy of a select pulse counts
   assign map_any = i_map_sel[0] | i_map_sel[1];
   assign loop_en = {|i_loop_en_cd, |i_loop_en_ab};

   // copy 0 drives branches A and B
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         copy_ff[0] <= 64'h0;
      end else begin
         copy_ff[0] <= fwd_in;
      end
   end

   // copy 1 drives C and D; its own flop so one fault cannot reach all four
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         copy_ff[1] <= 64'h0;
      end else begin
         copy_ff[1] <= fwd_in;
      end
   end

   // copy 0 feeds A and B, copy 1 feeds C and D
   // expanded branches swap in substitute poll bits after the tap
   genvar b;
   generate
      for (b = 0; b < `BBLU_BRANCHES; b++) begin : g_br
         bblu_pkg::bblu_fwd_t br_nxt;
         always_comb begin
            br_nxt = copy_ff[b / 2];
            if (i_exp_poll_sel[b]) begin
               br_nxt[`BBLU_POLL_LSB + `BBLU_POLL_HIGH]  = i_exp_poll[0];
               br_nxt[`BBLU_POLL_LSB + `BBLU_POLL_LOW]   = i_exp_poll[1];
               br_nxt[`BBLU_POLL_LSB + `BBLU_POLL_SEIZE] = i_exp_poll[2];
               br_nxt[`BBLU_POLL_LSB + `BBLU_POLL_DIGIT] = i_exp_poll[3];
            end
         end
         always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               br_ff[b] <= 64'h0;
            end else begin
               br_ff[b] <= br_nxt;
            end
         end
         assign o_br_addr[b]  = br_ff[b][`BBLU_ADDR_LSB +: `BBLU_ADDR_W];
         assign o_br_write[b] = br_ff[b][`BBLU_WRITE_LSB +: `BBLU_WRITE_W];
         assign o_br_poll[b]  = br_ff[b][`BBLU_POLL_LSB +: `BBLU_POLL_W];
      end
   endgenerate

   // two circuits of two sections each; tap is the unsubstituted copy
   // candidate bits come from the mapping table
   // each circuit sees only this bus, so loop data never crosses buses
   genvar s, m, i;
   generate
      for (s = 0; s < 4; s++) begin : g_sect
         // every section takes the same select pulses
         assign sect_if[s].map_pls = map_any;
         assign sect_if[s].en      = loop_en[s / 2];
         for (m = 0; m < `BBLU_MAPS; m++) begin : g_map
            for (i = 0; i < `BBLU_SECT_W; i++) begin : g_bit
               localparam int ENT = m * `BBLU_LOOP_W + (s % 2) * `BBLU_SECT_W + i;
               assign sect_if[s].cand[m][i] =
                  copy_ff[s / 2][MAP_TABLE[ENT * `BBLU_IDX_W +: `BBLU_IDX_W]];
            end
         end
         bblu_section u_section (
            .i_ref_clk (i_ref_clk),
            .i_rst_b   (i_rst_b),
            .s         (sect_if[s])
         );
         assign loop_word[s / 2][(s % 2) * `BBLU_SECT_W +: `BBLU_SECT_W] = sect_if[s].word;
         assign clearing[s] = sect_if[s].clearing;
      end
   endgenerate

   assign br_or = i_br_reply[0] | i_br_reply[1] | i_br_reply[2] | i_br_reply[3];
   // loop words join the concentration in the data field
   assign loop_any   = loop_word[0] | loop_word[1];
   assign loop_field = {8'h00, loop_any};
   // clamp blocks this unit's inputs; the chain still passes
   assign reply_local = clamp_ff ? 32'h0 : (br_or | loop_field);
   assign nxt_reply   = i_reply_chain | reply_local;
   assign clamp_set_any = |i_clamp_set;
   assign clamp_clr_any = |i_clamp_clr;
   // set beats clear when both arrive
   assign nxt_clamp = clamp_set_any | (clamp_ff & ~clamp_clr_any);

   // primary reply driver, flopped so the output is clean
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reply <= 32'h0;
      end else begin
         o_reply <= nxt_reply;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         clamp_ff <= 1'b0;
      end else begin
         clamp_ff <= nxt_clamp;
      end
   end

   // chained pulse leads; one cycle of lag per unit buys flopped outputs
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_map_sel_thru   <= 8'h00;
         o_clamp_set_thru <= 2'h0;
         o_clamp_clr_thru <= 2'h0;
      end else begin
         o_map_sel_thru   <= i_map_sel;
         o_clamp_set_thru <= i_clamp_set;
         o_clamp_clr_thru <= i_clamp_clr;
      end
   end

   // primary forward groups continue to the next unit
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_addr_thru  <= 16'h0;
         o_write_thru <= 40'h0;
         o_poll_thru  <= 8'h00;
      end else begin
         o_addr_thru  <= i_addr_grp;
         o_write_thru <= i_write_grp;
         o_poll_thru  <= i_poll_grp;
      end
   end

   // clearing flops shown one cycle behind
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_clearing <= 4'h0;
      end else begin
         o_clearing <= clearing;
      end
   end

   assign o_clamp = clamp_ff;
endmodule : bblu_top

/* File: bblu_props.sv */
// port-level assertions for the branching loop-around unit
`timescale 1ns/1ns
`include "bblu_cfg.svh"
module bblu_props (
   input wire logic                   i_ref_clk,
   input wire logic                   i_rst_b,
   input wire logic [15:0]            i_addr_grp,
   input wire logic [15:0]            o_addr_thru,
   input wire logic [39:0]            o_write_thru,
   input wire logic [3:0][39:0]       o_br_write,
   input wire logic [3:0][31:0]       i_br_reply,
   input wire logic [31:0]            i_reply_chain,
   input wire logic [31:0]            o_reply,
   input wire logic [1:0][3:0]        i_map_sel,
   input wire logic [1:0][3:0]        o_map_sel_thru,
   input wire logic [1:0]             i_clamp_set,
   input wire logic [1:0]             i_clamp_clr,
   input wire logic                   o_clamp,
   input wire logic [1:0]             i_loop_en_ab,
   input wire logic [3:0]             o_clearing
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // trailing edges that start a clearing cycle
   sequence s_sel_end;
      $past(|i_map_sel) && !(|i_map_sel);
   endsequence
   sequence s_en_end;
      $past(|i_loop_en_ab) && !(|i_loop_en_ab);
   endsequence
   // forward groups pass on one cycle later, branches one more
   a_fwd_thru: assert property ($past(i_rst_b) |-> o_addr_thru == $past(i_addr_grp))
      else $error("address not passed on one cycle later");
   a_branch_copy: assert property ($past(i_rst_b) |-> o_br_write[3] == $past(o_write_thru))
      else $error("branch write group differs from primary copy");
   // upper reply bits carry no loop data, so merge and clamp show plainly
   a_reply_merge: assert property ($past(i_rst_b) |-> o_reply[31:24] ==
      $past(i_reply_chain[31:24] | ({8{!o_clamp}} & (i_br_reply[0][31:24] |
      i_br_reply[1][31:24] | i_br_reply[2][31:24] | i_br_reply[3][31:24]))))
      else $error("reply word is not the gated merge");
   a_clamp_set: assert property (|i_clamp_set |=> o_clamp)
      else $error("clamp not set by pulse");
   a_clamp_clear: assert property (!(|i_clamp_set) && |i_clamp_clr |=> !o_clamp)
      else $error("clamp not cleared by pulse");
   a_clamp_hold: assert property (!(|{i_clamp_set, i_clamp_clr}) |=> $stable(o_clamp))
      else $error("clamp moved without pulse");
   a_select_chain: assert property ($past(i_rst_b) |-> o_map_sel_thru == $past(i_map_sel))
      else $error("select pulses not passed down the chain");
   a_sel_clears: assert property (s_sel_end |-> ##[1:3] (&o_clearing) ##[1:4]
      (o_clearing == 4'h0))
      else $error("select trailing edge clearing wrong");
   a_en_clears: assert property (s_en_end |-> ##[1:3] (&o_clearing[1:0]))
      else $error("enable trailing edge did not clear");
endmodule : bblu_props
bind bblu_top bblu_props u_bblu_props (.i_ref_clk, .i_rst_b, .i_addr_grp, .o_addr_thru,
   .o_write_thru, .o_br_write, .i_br_reply, .i_reply_chain, .o_reply, .i_map_sel,
   .o_map_sel_thru, .i_clamp_set, .i_clamp_clr, .o_clamp, .i_loop_en_ab, .o_clearing);

/* File: bblu_peer.sv */
// peripheral units answering on the four reply branches
`timescale 1ns/1ns
module bblu_peer #(
   parameter logic [11:0] CODE_BASE = 12'h0a0  // unit code of branch a, others follow
) (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst_b,
   input  wire logic [3:0][15:0]      i_br_addr,
   output logic      [3:0][31:0]      o_br_reply
);
   logic [3:0] sync_seen_ff;

   // unit code compare, mode bit echoed
   // a code counts only right after the sync bit (bit 13)
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_br_reply   <= '0;
         sync_seen_ff <= 4'h0;
      end else begin
         for (int b = 0; b < 4; b++) begin
            sync_seen_ff[b] <= i_br_addr[b][13];
            // unaddressed units leave the shunt lines at idle zero
            o_br_reply[b] <= (sync_seen_ff[b] && i_br_addr[b][11:0] == CODE_BASE + 12'(b)) ?
               {4'h0, i_br_addr[b][12], 3'(b), 12'h5a3, i_br_addr[b][11:0]} : 32'h0;
         end
      end
   end
endmodule : bblu_peer

/* File: tb_bblu_top.sv */
// self-checking bench for the branching loop-around unit
`timescale 1ns/1ns
module tb_bblu_top;
   logic              i_ref_clk = 1'b0;
   logic              i_rst_b, o_clamp, clamp_m;
   logic [15:0]       i_addr_grp, o_addr_thru, a1, a2;
   logic [39:0]       i_write_grp, o_write_thru, w1, w2;
   logic [7:0]        i_poll_grp, o_poll_thru, p1, p2;
   logic [3:0][15:0]  o_br_addr;
   logic [3:0][39:0]  o_br_write;
   logic [3:0][7:0]   o_br_poll;
   logic [3:0]        i_exp_poll_sel, i_exp_poll, o_clearing;
   logic [3:0][31:0]  i_br_reply;
   logic [31:0]       i_reply_chain, o_reply, rexp;
   logic [1:0]        i_loop_en_ab, i_loop_en_cd, i_clamp_set, i_clamp_clr, s1, c1;
   logic [1:0]        o_clamp_set_thru, o_clamp_clr_thru;
   logic [1:0][3:0]   i_map_sel, o_map_sel_thru;
   int                fails, checks_done, seed;

   bblu_top u_bblu_top (.i_ref_clk, .i_rst_b, .i_addr_grp, .i_write_grp, .i_poll_grp,
      .o_addr_thru, .o_write_thru, .o_poll_thru, .o_br_addr, .o_br_write, .o_br_poll,
      .i_exp_poll_sel, .i_exp_poll, .i_br_reply, .i_reply_chain, .o_reply, .i_loop_en_ab,
      .i_loop_en_cd, .i_map_sel, .o_map_sel_thru, .i_clamp_set, .i_clamp_clr,
      .o_clamp_set_thru, .o_clamp_clr_thru, .o_clamp, .o_clearing);
   bblu_peer u_bblu_peer (.i_ref_clk, .i_rst_b, .i_br_addr(o_br_addr), .o_br_reply(i_br_reply));

   // 25 mhz clock
   always #20 i_ref_clk = ~i_ref_clk;

   // expected pipeline, clamp state and reply merge
   always @(posedge i_ref_clk) begin
      {a2, a1, w2, w1, p2, p1, s1, c1} <= {a1, i_addr_grp, w1, i_write_grp, p1, i_poll_grp,
         i_clamp_set, i_clamp_clr};
      rexp <= i_reply_chain | (clamp_m ? 32'h0 :
         (i_br_reply[0] | i_br_reply[1] | i_br_reply[2] | i_br_reply[3]));
      clamp_m <= i_rst_b & ((|i_clamp_set) | (~(|i_clamp_clr) & clamp_m));
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // substituted poll bits go out only on selected branches
   function automatic logic [7:0] poll_exp(input logic [7:0] p, input logic s,
                                           input logic [3:0] x);
      return s ? {p[7], x, p[2:0]} : p;
   endfunction : poll_exp

   // default table: mapping m bit i takes forward bit (24*(m-1)+i) mod 64
   function automatic logic [23:0] cap_exp(input int m, input logic [63:0] f);
      logic [23:0] c;
      c = 24'h0;
      for (int i = 0; i < 24; i++) begin
         c[i] = (m == 0) ? 1'b0 : f[(24 * (m - 1) + i) % 64];
      end
      return c;
   endfunction : cap_exp

   // select mapping, capture data, hold it, then read it through one enable copy
   task automatic loop_test(input int m, input int ctl, input bit cd);
      logic [63:0] f;
      f = {$random(seed), $random(seed)};
      f[11] = 1'b1;  // keeps the peers silent so only loop data reaches the reply
      @(posedge i_ref_clk) i_map_sel[ctl][m] <= 1'b1;
      @(posedge i_ref_clk) i_map_sel <= '0;
      @(negedge i_ref_clk);
      chk(o_map_sel_thru, 8'h01 << (ctl * 4 + m));
      repeat (8) @(posedge i_ref_clk);
      {i_poll_grp, i_write_grp, i_addr_grp} <= f;
      repeat (3) @(posedge i_ref_clk);
      {i_poll_grp, i_write_grp, i_addr_grp} <= 64'h0;
      repeat (3) @(posedge i_ref_clk);
      if (cd) i_loop_en_cd[ctl] <= 1'b1;
      else i_loop_en_ab[ctl] <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk(o_reply, {8'h0, cap_exp(m, f)});
      @(posedge i_ref_clk) {i_loop_en_ab, i_loop_en_cd} <= 4'h0;
      repeat (8) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk(o_reply, 64'h0);
   endtask : loop_test

   task automatic conclude();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // watchdog well beyond the expected run length
   initial begin
      repeat (3000) @(posedge i_ref_clk);
      fails++;
      conclude();
   end

   // main sequence: reset, random traffic with clamp pulses, loop-around per mapping
   initial begin
      seed = 32'h2962;
      i_rst_b = 1'b0;
      {i_addr_grp, i_write_grp, i_poll_grp, i_reply_chain} = '0;
      {i_loop_en_ab, i_loop_en_cd, i_clamp_set, i_clamp_clr, i_map_sel} = '0;
      {i_exp_poll_sel, i_exp_poll} = 8'($random(seed));
      repeat (10) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      @(negedge i_ref_clk);
      chk({o_clamp, o_clearing, o_reply}, 64'h0);
      for (int n = 0; n < 300; n++) begin
         @(posedge i_ref_clk);
         // sync on bit 13 in the cycle before each unit code
         i_addr_grp <= n[0] ? {2'($random(seed)), 1'b0, 1'($random(seed)),
            12'h0a0 + 12'($random(seed) & 3)} : {2'($random(seed)), 1'b1, 13'($random(seed))};
         i_write_grp <= 40'({$random(seed), $random(seed)});
         i_poll_grp <= 8'($random(seed));
         i_reply_chain <= (($random(seed) & 3) == 0) ? 32'($random(seed)) : 32'h0;
         // either control's clamp lead, sometimes both together
         i_clamp_set <= (($random(seed) & 7) == 0) ? 2'($random(seed)) : 2'h0;
         i_clamp_clr <= (($random(seed) & 3) == 0) ? 2'($random(seed)) : 2'h0;
         @(negedge i_ref_clk);
         chk({o_addr_thru, o_poll_thru, o_clamp_set_thru, o_clamp_clr_thru}, {a1, p1, s1, c1});
         chk(o_write_thru, w1);
         for (int b = 0; b < 4; b++) begin
            chk({o_br_addr[b], o_br_write[b]}, {a2, w2});
            chk(o_br_poll[b], poll_exp(p2, i_exp_poll_sel[b], i_exp_poll));
         end
         chk(o_reply, rexp);
         chk(o_clamp, clamp_m);
      end
      @(posedge i_ref_clk) {i_clamp_set, i_clamp_clr, i_reply_chain} <= {4'h3, 32'h0};
      @(posedge i_ref_clk) i_clamp_clr <= 2'h0;
      for (int k = 0; k < 8; k++) begin
         loop_test(k % 4, k % 2, k / 4);
      end
      conclude();
   end
endmodule : tb_bblu_top
